// ===== rtl/bit_error_injector.v
// Bit error injector for a 32-lane pattern stream with AXI4-Lite registers
`timescale 1ns/100ps
`include "bit_error_injector_regs.vh"
module bit_error_injector (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] din,
  input wire din_valid,
  input wire seg_prbs,
  input wire [8:0] seg_block,
  input wire aux_in,
  output wire [31:0] dout,
  output wire dout_valid
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RESP = 2'b10;

  reg [1:0] wst_q;
  reg awready_q;
  reg wready_q;
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] waddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  reg [9:0] ctrl_q;
  reg [5:0] lane_q;
  reg [11:0] rate_q;
  reg [8:0] blk_q;
  reg [4:0] rot_q;
  reg [2:0] pend_q;
  reg [15:0] count_q;
  reg [31:0] dout_q;
  reg dout_valid_q;

  reg [31:0] ctrl_m;
  reg [31:0] lane_m;
  reg [31:0] rate_m;
  reg [31:0] blk_m;
  reg [1:0] wr_resp;
  reg wr_ctrl;
  reg wr_lane;
  reg wr_rate;
  reg wr_blk;
  reg wr_shot;
  reg [31:0] rd_data;
  reg [1:0] rd_resp;
  reg [3:0] pend_sum;

  wire aux_lvl;
  wire aux_rise;
  wire tick;
  wire do_write;
  wire enable;
  wire [1:0] src;
  wire single;
  wire rotate;
  wire [3:0] mant;
  wire [3:0] expo;
  wire [2:0] comb_n;
  wire gate_ok;
  wire seg_ok;
  wire rate_run;
  wire ins;
  wire [4:0] lane_idx;

  function [31:0] strb_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      strb_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          strb_merge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  // Lane number 1..32 to bit index 0..31
  function [4:0] lane_bit;
    input [5:0] lane;
    reg [5:0] t;
    begin
      t = lane - `BEI_LANE_MIN;
      lane_bit = t[4:0];
    end
  endfunction

  aux_sync u_aux_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(aux_in),
    .level(aux_lvl),
    .rise(aux_rise)
  );

  assign enable = ctrl_q[`BEI_CTRL_ENABLE];
  assign src = ctrl_q[`BEI_CTRL_SRC_HI:`BEI_CTRL_SRC_LO];
  assign single = ctrl_q[`BEI_CTRL_SINGLE];
  assign rotate = ctrl_q[`BEI_CTRL_ROTATE];
  assign mant = rate_q[`BEI_RATE_MANT_HI:`BEI_RATE_MANT_LO];
  assign expo = rate_q[`BEI_RATE_EXP_HI:`BEI_RATE_EXP_LO];
  assign comb_n = 3'h1 << ctrl_q[`BEI_CTRL_COMB_HI:`BEI_CTRL_COMB_LO];

  // Rate generator runs only for continuous internal or gated timing
  assign rate_run = din_valid & enable & ~single & (src != `BEI_SRC_EXT_TRIG);

  rate_gen u_rate_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .adv(rate_run),
    .clr(~enable | single | (src == `BEI_SRC_EXT_TRIG)),
    .mant(mant),
    .expo(expo),
    .tick(tick)
  );

  assign gate_ok = (src != `BEI_SRC_EXT_GATE) | aux_lvl;
  assign seg_ok = ~ctrl_q[`BEI_CTRL_CONFINE] |
                  ((seg_prbs == ctrl_q[`BEI_CTRL_SEG_PRBS]) & (seg_block == blk_q));
  assign ins = din_valid & enable & (pend_q != 3'h0) & gate_ok & seg_ok;
  assign lane_idx = rotate ? rot_q : lane_bit(lane_q);

  // Write decode and value checks
  always @* begin
    ctrl_m = strb_merge({22'h0, ctrl_q}, wdata_q, wstrb_q);
    lane_m = strb_merge({26'h0, lane_q}, wdata_q, wstrb_q);
    rate_m = strb_merge({20'h0, rate_q}, wdata_q, wstrb_q);
    blk_m = strb_merge({23'h0, blk_q}, wdata_q, wstrb_q);
    wr_resp = `BEI_RESP_OKAY;
    wr_ctrl = 1'b0;
    wr_lane = 1'b0;
    wr_rate = 1'b0;
    wr_blk = 1'b0;
    wr_shot = 1'b0;
    if (waddr_q == `BEI_ADDR_CTRL) begin
      if ((ctrl_m[`BEI_CTRL_SRC_HI:`BEI_CTRL_SRC_LO] != `BEI_SRC_INTERNAL) &
          ~ctrl_m[`BEI_CTRL_AUX_INJ]) begin
        wr_resp = `BEI_RESP_SLVERR;
      end else if ((ctrl_m[`BEI_CTRL_SRC_HI:`BEI_CTRL_SRC_LO] == 2'h3) |
                   (ctrl_m[`BEI_CTRL_COMB_HI:`BEI_CTRL_COMB_LO] == 2'h3)) begin
        wr_resp = `BEI_RESP_SLVERR;
      end else begin
        wr_ctrl = 1'b1;
      end
    end else if (waddr_q == `BEI_ADDR_LANE) begin
      if ((lane_m[5:0] < `BEI_LANE_MIN) | (lane_m[5:0] > `BEI_LANE_MAX) |
          (lane_m[31:6] != 26'h0)) begin
        wr_resp = `BEI_RESP_SLVERR;
      end else begin
        wr_lane = 1'b1;
      end
    end else if (waddr_q == `BEI_ADDR_RATE) begin
      if ((rate_m[`BEI_RATE_MANT_HI:`BEI_RATE_MANT_LO] < `BEI_MANT_MIN) |
          (rate_m[`BEI_RATE_MANT_HI:`BEI_RATE_MANT_LO] > `BEI_MANT_MAX) |
          (rate_m[`BEI_RATE_EXP_HI:`BEI_RATE_EXP_LO] < `BEI_EXP_MIN) |
          (rate_m[`BEI_RATE_EXP_HI:`BEI_RATE_EXP_LO] > `BEI_EXP_MAX)) begin
        wr_resp = `BEI_RESP_SLVERR;
      end else if ((rate_m[`BEI_RATE_EXP_HI:`BEI_RATE_EXP_LO] == `BEI_EXP_MIN) &
                   (rate_m[`BEI_RATE_MANT_HI:`BEI_RATE_MANT_LO] > `BEI_MANT_MAX_E3)) begin
        wr_resp = `BEI_RESP_SLVERR;
      end else begin
        wr_rate = 1'b1;
      end
    end else if (waddr_q == `BEI_ADDR_SHOT) begin
      if (~single | (src == `BEI_SRC_EXT_TRIG)) begin
        wr_resp = `BEI_RESP_SLVERR;
      end else begin
        wr_shot = wstrb_q[0] & wdata_q[0];
      end
    end else if (waddr_q == `BEI_ADDR_BLOCK) begin
      wr_blk = 1'b1;
    end else if (waddr_q == `BEI_ADDR_STATUS) begin
      wr_resp = `BEI_RESP_SLVERR;
    end else begin
      wr_resp = `BEI_RESP_DECERR;
    end
  end

  // Read decode
  always @* begin
    rd_data = 32'h0;
    rd_resp = `BEI_RESP_OKAY;
    if (s_axi_araddr == `BEI_ADDR_CTRL) begin
      rd_data = {22'h0, ctrl_q};
    end else if (s_axi_araddr == `BEI_ADDR_LANE) begin
      rd_data = {26'h0, lane_q};
    end else if (s_axi_araddr == `BEI_ADDR_RATE) begin
      rd_data = {20'h0, rate_q};
    end else if (s_axi_araddr == `BEI_ADDR_SHOT) begin
      rd_data = 32'h0;
    end else if (s_axi_araddr == `BEI_ADDR_BLOCK) begin
      rd_data = {23'h0, blk_q};
    end else if (s_axi_araddr == `BEI_ADDR_STATUS) begin
      rd_data = {count_q, 7'h0, pend_q, 1'b0, lane_idx};
    end else begin
      rd_resp = `BEI_RESP_DECERR;
    end
  end

  assign do_write = aw_held_q & w_held_q & (wst_q == ST_IDLE);

  // Write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= ST_IDLE;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `BEI_RESP_OKAY;
    end else begin
      case (wst_q)
        ST_IDLE: begin
          if (s_axi_awvalid & awready_q) begin
            aw_held_q <= 1'b1;
            waddr_q <= {s_axi_awaddr[7:2], 2'b00};
            awready_q <= 1'b0;
          end else if (~aw_held_q) begin
            awready_q <= 1'b1;
          end
          if (s_axi_wvalid & wready_q) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            wready_q <= 1'b0;
          end else if (~w_held_q) begin
            wready_q <= 1'b1;
          end
          if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_resp;
            wst_q <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            wst_q <= ST_IDLE;
          end
        end
        default: begin
          wst_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `BEI_RESP_OKAY;
    end else if (rvalid_q) begin
      if (s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end else if (s_axi_arvalid & arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_resp;
    end else begin
      arready_q <= 1'b1;
    end
  end

  // Configuration registers, kept while disabled
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `BEI_CTRL_RESET;
      lane_q <= `BEI_LANE_RESET;
      rate_q <= `BEI_RATE_RESET;
      blk_q <= `BEI_BLOCK_RESET;
    end else if (do_write) begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_m[9:0];
      end
      if (wr_lane) begin
        lane_q <= lane_m[5:0];
      end
      if (wr_rate) begin
        rate_q <= rate_m[11:0];
      end
      if (wr_blk) begin
        blk_q <= blk_m[8:0];
      end
    end
  end

  // Pending insertions from ticks, edges and one-shot commands
  always @* begin
    pend_sum = {1'b0, pend_q};
    if (tick & gate_ok) begin
      pend_sum = pend_sum + 4'h1;
    end
    if (enable & aux_rise & (src == `BEI_SRC_EXT_TRIG)) begin
      pend_sum = pend_sum + 4'h1;
    end
    if (do_write & wr_shot) begin
      pend_sum = pend_sum + {1'b0, comb_n};
    end
    if (ins) begin
      pend_sum = pend_sum - 4'h1;
    end
  end

  // Insertion datapath
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 3'h0;
      rot_q <= 5'h00;
      count_q <= 16'h0;
      dout_q <= 32'h0;
      dout_valid_q <= 1'b0;
    end else begin
      if (~enable) begin
        pend_q <= 3'h0;
      end else if (pend_sum > 4'h7) begin
        pend_q <= 3'h7;
      end else begin
        pend_q <= pend_sum[2:0];
      end
      if (ins & rotate) begin
        rot_q <= rot_q + 5'h01;
      end
      if (ins) begin
        count_q <= count_q + 16'h0001;
      end
      dout_valid_q <= din_valid;
      if (din_valid) begin
        dout_q <= din ^ ({31'h0, ins} << lane_idx);
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign dout = dout_q;
  assign dout_valid = dout_valid_q;
endmodule // bit_error_injector

// ===== shared/bit_error_injector_regs.vh
// Register map, field positions, reset values and constants of the bit error injector
`ifndef BIT_ERROR_INJECTOR_REGS_VH
`define BIT_ERROR_INJECTOR_REGS_VH

// Byte addresses
`define BEI_ADDR_CTRL 8'h00
`define BEI_ADDR_LANE 8'h04
`define BEI_ADDR_RATE 8'h08
`define BEI_ADDR_SHOT 8'h0c
`define BEI_ADDR_BLOCK 8'h10
`define BEI_ADDR_STATUS 8'h14

// Control fields
`define BEI_CTRL_ENABLE 0
`define BEI_CTRL_SRC_LO 1
`define BEI_CTRL_SRC_HI 2
`define BEI_CTRL_SINGLE 3
`define BEI_CTRL_ROTATE 4
`define BEI_CTRL_AUX_INJ 5
`define BEI_CTRL_CONFINE 6
`define BEI_CTRL_SEG_PRBS 7
`define BEI_CTRL_COMB_LO 8
`define BEI_CTRL_COMB_HI 9

// Source codes
`define BEI_SRC_INTERNAL 2'h0
`define BEI_SRC_EXT_TRIG 2'h1
`define BEI_SRC_EXT_GATE 2'h2

// Rate fields
`define BEI_RATE_MANT_LO 0
`define BEI_RATE_MANT_HI 3
`define BEI_RATE_EXP_LO 8
`define BEI_RATE_EXP_HI 11

// Limits
`define BEI_MANT_MIN 4'h1
`define BEI_MANT_MAX 4'h9
`define BEI_MANT_MAX_E3 4'h5
`define BEI_EXP_MIN 4'h3
`define BEI_EXP_MAX 4'hc
`define BEI_LANE_MIN 6'h01
`define BEI_LANE_MAX 6'h20
`define BEI_LANES 32
`define BEI_WORD_BITS 32

// Reset values
`define BEI_CTRL_RESET 10'h000
`define BEI_LANE_RESET 6'h01
`define BEI_RATE_RESET 12'h601
`define BEI_BLOCK_RESET 9'h001

// Bus answers
`define BEI_RESP_OKAY 2'h0
`define BEI_RESP_SLVERR 2'h2
`define BEI_RESP_DECERR 2'h3

`endif

// ===== rtl/aux_sync.v
// Two-stage synchroniser and rising edge detector for the auxiliary input
`timescale 1ns/100ps
module aux_sync (
  input wire aclk,
  input wire aresetn,
  input wire pin,
  output wire level,
  output wire rise
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
endmodule // aux_sync

// ===== rtl/rate_gen.v
// Error rate tick generator: mantissa times ten to the minus exponent per bit
`timescale 1ns/100ps
`include "bit_error_injector_regs.vh"
module rate_gen (
  input wire aclk,
  input wire aresetn,
  input wire adv,
  input wire clr,
  input wire [3:0] mant,
  input wire [3:0] expo,
  output wire tick
);
  reg [39:0] acc_q;
  wire [39:0] step;
  wire [39:0] sum;
  wire [39:0] lim;

  function [39:0] pow10;
    input [3:0] e;
    integer i;
    reg [39:0] p;
    begin
      p = 40'h1;
      for (i = 0; i < 13; i = i + 1) begin
        if (i < e) begin
          p = (p << 3) + (p << 1);
        end
      end
      pow10 = p;
    end
  endfunction

  // Bits per word times mantissa
  assign step = {31'h0, mant, 5'h0};
  assign sum = acc_q + step;
  assign lim = pow10(expo);
  assign tick = adv & (sum >= lim);

  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 40'h0;
    end else if (clr) begin
      acc_q <= 40'h0;
    end else if (adv) begin
      acc_q <= tick ? (sum - lim) : sum;
    end
  end
endmodule // rate_gen

// ===== tb/bei_sva.sv
// Port assertions for the bit error injector
`timescale 1ns/100ps
module bei_sva (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] din,
  input logic din_valid,
  input logic [31:0] dout,
  input logic dout_valid
);
  logic en_q, busy_q, ctl_q, wen_q;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Shadow of the master enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        busy_q <= 1'b1;
        ctl_q <= s_axi_awaddr[7:2] == 6'h00;
      end
      if (s_axi_wvalid && s_axi_wready) wen_q <= s_axi_wdata[0];
      if (s_axi_bvalid && s_axi_bready) begin
        busy_q <= 1'b0;
        if (ctl_q && s_axi_bresp == 2'h0) en_q <= wen_q;
      end
    end
  end
  a_one_flip: assert property (
    din_valid |=> $countones(dout ^ $past(din)) <= 1) else $error("several bits inverted");
  a_no_err_off: assert property (
    !en_q && !busy_q && !s_axi_awvalid && din_valid |=> dout == $past(din))
    else $error("error inserted while disabled");
  a_idle_hold: assert property (
    !din_valid |=> !dout_valid && $stable(dout)) else $error("output moved without input");
  a_valid_next: assert property (
    din_valid |=> dout_valid) else $error("word lost");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data missing");
  a_read_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_b_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response not released");
endmodule // bei_sva
bind bit_error_injector bei_sva chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .din(din), .din_valid(din_valid), .dout(dout),
  .dout_valid(dout_valid)
);

// ===== tb/stream_sink.sv
// Error detector model receiving the pattern stream
`timescale 1ns/100ps
module stream_sink (
  input logic aclk,
  input logic [31:0] din,
  input logic din_valid,
  input logic allow,
  input logic [31:0] dout,
  input logic dout_valid,
  output int flips = 0,
  output int multi = 0,
  output int stray = 0,
  output int steps = 0,
  output int last_lane = 0
);
  logic [31:0] sent_q = 32'h0;
  logic allow_q = 1'b0;
  logic [31:0] diff;
  int i;
  always @(posedge aclk) begin
    if (dout_valid) begin
      diff = dout ^ sent_q;
      if ($countones(diff) > 1) multi <= multi + 1;
      if ($countones(diff) == 1) begin
        flips <= flips + 1;
        if (!allow_q) stray <= stray + 1;
        for (i = 0; i < 32; i++) begin
          if (diff[i] && i == last_lane % 32) steps <= steps + 1;
          if (diff[i]) last_lane <= i + 1;
        end
      end
    end
    if (din_valid) begin
      sent_q <= din;
      allow_q <= allow;
    end
  end
endmodule // stream_sink

// ===== tb/tb_top.sv
// Self-checking bench for the bit error injector
`timescale 1ns/100ps
`include "bit_error_injector_regs.vh"
module tb_top;
  localparam logic [1:0] r_ok = `BEI_RESP_OKAY;
  localparam logic [1:0] r_se = `BEI_RESP_SLVERR;
  localparam logic [1:0] r_de = `BEI_RESP_DECERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, din = 32'h0;
  logic din_valid = 1'b0, seg_prbs = 1'b0, aux_in = 1'b0, allow = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [8:0] seg_block = 9'h001;
  wire awready, wready, bvalid, arready, rvalid, dout_valid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, dout;
  int flips, multi, stray, steps, last_lane;
  int bad_count = 0, n_compared = 0, seed = 28, errs, st, s0;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  always #5 aclk = ~aclk;
  bit_error_injector uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .din(din), .din_valid(din_valid), .seg_prbs(seg_prbs), .seg_block(seg_block),
    .aux_in(aux_in), .dout(dout), .dout_valid(dout_valid));
  stream_sink sink (.aclk(aclk), .din(din), .din_valid(din_valid), .allow(allow),
    .dout(dout), .dout_valid(dout_valid), .flips(flips), .multi(multi), .stray(stray),
    .steps(steps), .last_lane(last_lane));
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic hang;
    bad_count++;
    $display("ERROR handshake expected answer seen none");
    summarize();
  endtask
  task automatic fin(input string name);
    $display("test %s done", name);
  endtask
  // Response monitor takes the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) cmp("bresp", {32'h0, exp_b.pop_front()}, {32'h0, bresp});
    if (rvalid && rready) cmp("read", exp_r.pop_front(), {rresp, rdata});
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) hang();
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    exp_r.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 40) hang();
    @(posedge aclk);
  endtask
  // Back-to-back random words; aux pulses and segment filter on request
  task automatic words(input int n, input int auxm, input int alm);
    int f0, i;
    logic p;
    logic [8:0] b;
    f0 = flips;
    for (i = 0; i < n; i++) begin
      p = $random(seed);
      b = $random(seed) & 1 ? 9'h002 : 9'h001;
      din <= $random(seed);
      din_valid <= 1'b1;
      seg_prbs <= p;
      seg_block <= b;
      allow <= alm == 2 ? p && b == 9'h002 : alm == 1;
      aux_in <= auxm == 1 && i % 20 < 10;
      @(posedge aclk);
    end
    din_valid <= 1'b0;
    aux_in <= 1'b0;
    repeat (8) @(posedge aclk);
    errs = flips - f0;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(`BEI_ADDR_CTRL, 32'h0, r_ok);
    rd(`BEI_ADDR_LANE, 32'h1, r_ok);
    rd(`BEI_ADDR_RATE, 32'h601, r_ok);
    rd(`BEI_ADDR_BLOCK, 32'h1, r_ok);
    rd(8'h18, 32'h0, r_de);
    fin("reset values");
    wr(`BEI_ADDR_RATE, 32'h306, r_se);
    wr(`BEI_ADDR_RATE, 32'hd01, r_se);
    wr(`BEI_ADDR_RATE, 32'h300, r_se);
    wr(`BEI_ADDR_RATE, 32'h305, r_ok);
    wr(`BEI_ADDR_LANE, 32'h0, r_se);
    wr(`BEI_ADDR_LANE, 32'h21, r_se);
    wr(`BEI_ADDR_CTRL, 32'h3, r_se);
    wr(`BEI_ADDR_CTRL, 32'h5, r_se);
    wr(`BEI_ADDR_CTRL, 32'h27, r_se);
    wr(`BEI_ADDR_CTRL, 32'h301, r_se);
    wr(`BEI_ADDR_SHOT, 32'h1, r_se);
    wr(8'h18, 32'h0, r_de);
    wr(`BEI_ADDR_STATUS, 32'h0, r_se);
    rd(`BEI_ADDR_CTRL, 32'h0, r_ok);
    fin("refusals");
    wstrb <= 4'h1;
    wr(`BEI_ADDR_RATE, 32'h6, r_se);
    wstrb <= 4'h2;
    wr(`BEI_ADDR_RATE, 32'hc00, r_ok);
    wstrb <= 4'hf;
    rd(`BEI_ADDR_RATE, 32'hc05, r_ok);
    wr(`BEI_ADDR_RATE, 32'h305, r_ok);
    fin("byte strobes");
    wr(`BEI_ADDR_LANE, 32'h5, r_ok);
    wr(`BEI_ADDR_CTRL, 32'h9, r_ok);
    words(30, 0, 1);
    cmp("no command", 0, errs);
    wr(`BEI_ADDR_SHOT, 32'h1, r_ok);
    words(20, 0, 1);
    cmp("one shot", 1, errs);
    cmp("fixed lane", 5, last_lane);
    rd(`BEI_ADDR_STATUS, 32'h00010004, r_ok);
    fin("one shot");
    wr(`BEI_ADDR_CTRL, 32'h219, r_ok);
    st = steps;
    wr(`BEI_ADDR_SHOT, 32'h1, r_ok);
    words(20, 0, 1);
    cmp("combined", 4, errs);
    cmp("rotation", 1, steps - st >= 3);
    wr(`BEI_ADDR_CTRL, 32'h0, r_ok);
    rd(`BEI_ADDR_LANE, 32'h5, r_ok);
    rd(`BEI_ADDR_RATE, 32'h305, r_ok);
    fin("combined rotate");
    wr(`BEI_ADDR_CTRL, 32'h1, r_ok);
    words(100, 0, 1);
    cmp("rate", 1, errs inside {15, 16});
    wr(`BEI_ADDR_CTRL, 32'h22, r_ok);
    words(40, 1, 0);
    cmp("disabled", 0, errs);
    wr(`BEI_ADDR_CTRL, 32'h2b, r_ok);
    wr(`BEI_ADDR_SHOT, 32'h1, r_se);
    wr(`BEI_ADDR_CTRL, 32'h23, r_ok);
    words(40, 1, 1);
    cmp("edges", 2, errs);
    fin("rate and edges");
    wr(`BEI_ADDR_CTRL, 32'h25, r_ok);
    words(100, 0, 1);
    cmp("gate low", 0, errs);
    words(100, 1, 1);
    cmp("gate high", 1, errs > 0);
    wr(`BEI_ADDR_BLOCK, 32'h2, r_ok);
    wr(`BEI_ADDR_CTRL, 32'hc1, r_ok);
    s0 = stray;
    words(200, 0, 2);
    cmp("segment", 1, errs > 0 && stray == s0);
    cmp("single bit", 0, multi);
    fin("gate and segment");
    summarize();
  end
endmodule // tb_top
